// File: hw/fpebpt_pkg.sv
// constants, types and decode helpers for the flash sequencer register and array map
package fpebpt_pkg;

    // ****************************************
    // word indexes (byte address = 4 * index)
    // ****************************************
    localparam logic [15:0] CTRL_IDX = 16'hfe08;
    localparam logic [15:0] PROT_IDX = 16'hff7e;
    localparam logic [15:0] SEC_IDX = 16'hfe0d;
    localparam logic [15:0] USER_FIRST = 16'hf600;
    localparam logic [15:0] USER_LAST = 16'hfdff;
    localparam logic [15:0] VEC_FIRST = 16'hffdc;
    localparam logic [15:0] VEC_LAST = 16'hffff;

    // ****************************************
    // array geometry
    // ****************************************
    localparam logic [15:0] USER_BYTES = 16'h0800;
    localparam logic [11:0] ARRAY_BYTES = 12'h824;
    localparam int unsigned PAGE_BYTES = 64;
    localparam int unsigned MEM_IDX_W = 12;
    localparam int unsigned PAGE_W = 6;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ****************************************
    // control fields and reset values
    // ****************************************
    localparam int unsigned PROGRAM_SELECT_BIT = 0;
    localparam int unsigned ERASE_SELECT_BIT = 1;
    localparam int unsigned MASS_SELECT_BIT = 2;
    localparam int unsigned HIGH_VOLTAGE_ENABLE_BIT = 3;
    localparam int unsigned SEC_LOCK_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PROT_RESET = 8'hff;
    localparam logic [7:0] PROT_NONE = 8'hff;
    localparam logic [7:0] SEC_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {RGN_NONE, RGN_CTRL, RGN_PROT, RGN_SEC, RGN_USER, RGN_VEC} fpebpt_region_t;

    function automatic fpebpt_region_t fpebpt_region(input logic [31:0] addr);
        logic [15:0] idx;
        idx = addr[17:2];
        if (addr[31:18] != 14'h0000 || addr[1:0] != 2'h0)
            return RGN_NONE;
        if (idx == CTRL_IDX)
            return RGN_CTRL;
        if (idx == PROT_IDX)
            return RGN_PROT;
        if (idx == SEC_IDX)
            return RGN_SEC;
        if (idx >= USER_FIRST && idx <= USER_LAST)
            return RGN_USER;
        if (idx >= VEC_FIRST && idx <= VEC_LAST)
            return RGN_VEC;
        return RGN_NONE;
    endfunction : fpebpt_region

    // user bytes first, vectors packed right behind them
    function automatic logic [11:0] fpebpt_mem_index(input logic [31:0] addr);
        logic [15:0] off;
        off = (addr[17:2] >= VEC_FIRST) ? addr[17:2] - VEC_FIRST + USER_BYTES
                                        : addr[17:2] - USER_FIRST;
        return off[11:0];
    endfunction : fpebpt_mem_index

    // protection covers everything from {1, bpr, 7'h00} upward unless bpr is all ones
    function automatic logic fpebpt_protected(input logic [31:0] addr, input logic [7:0] bpr);
        return (bpr != PROT_NONE) && (addr[17:2] >= {1'b1, bpr, 7'h00});
    endfunction : fpebpt_protected

endpackage : fpebpt_pkg

// File: hw/fpebpt_top.sv
// flash array with byte program, page and mass erase, behind an axi4-lite slave
//
// Notes on behaviour
// - erased cells read one, programmed cells read zero
// - erase unit is a 64-byte page of two rows, fully cleared
// - array is programmed byte by byte but erased only by whole pages
// - array holds 2048 user bytes and 36 vector bytes; the protection byte is a register outside it
// - user bytes at f600-fdff, vectors at ffdc-ffff, protection at ff7e
// - a security lock blocks outside viewing of array contents
`timescale 1ns/1ps
module fpebpt_top
    import fpebpt_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    // write address and data
    input wire logic [31:0] S_AXI_AWADDR_IN,
    input wire logic [2:0] S_AXI_AWPROT_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    // write response
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // read
    input wire logic [31:0] S_AXI_ARADDR_IN,
    input wire logic [2:0] S_AXI_ARPROT_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // charge pump state
    output logic HV_ACTIVE_OUT
);

    // ****************************************
    // state
    // ****************************************
    logic [7:0] mem [0:2083];
    logic [7:0] flash_operation_control;
    logic [7:0] flash_block_protection;
    logic [7:0] security;
    logic [31:0] aw_addr;
    logic aw_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_full;
    logic [PAGE_W-1:0] erase_page;
    logic erase_armed;

    // ****************************************
    // write and read decode
    // ****************************************
    fpebpt_region_t wr_rgn;
    fpebpt_region_t rd_rgn;
    logic [11:0] wr_mi;
    logic [11:0] rd_mi;
    logic do_write;
    logic wr_byte;
    logic wr_array;
    logic wr_prot;
    logic prog_hit;
    logic latch_hit;
    logic hv_rise;
    logic page_erase;
    logic mass_erase;
    logic ar_hs;
    logic rd_array;
    logic rd_secured;
    logic [11:0] nb_idx;
    logic [7:0] prog_old;
    logic [7:0] nb_old;

    assign wr_rgn = fpebpt_region(aw_addr);
    assign rd_rgn = fpebpt_region(S_AXI_ARADDR_IN);
    assign wr_mi = fpebpt_mem_index(aw_addr);
    assign rd_mi = fpebpt_mem_index(S_AXI_ARADDR_IN);
    assign do_write = aw_full && w_full && !S_AXI_BVALID_OUT;
    assign wr_byte = do_write && w_strb[0];
    assign wr_array = (wr_rgn == RGN_USER) || (wr_rgn == RGN_VEC);
    assign wr_prot = fpebpt_protected(aw_addr, flash_block_protection);
    // programming can only pull bits to zero, one byte per write
    assign prog_hit = wr_byte && wr_array && !wr_prot
        && flash_operation_control[PROGRAM_SELECT_BIT]
        && flash_operation_control[HIGH_VOLTAGE_ENABLE_BIT]
        && !flash_operation_control[ERASE_SELECT_BIT];
    // the target page is named by a write while erase is selected and the pump is off
    assign latch_hit = wr_byte && wr_array && !wr_prot
        && flash_operation_control[ERASE_SELECT_BIT]
        && !flash_operation_control[HIGH_VOLTAGE_ENABLE_BIT];
    assign hv_rise = wr_byte && (wr_rgn == RGN_CTRL) && w_data[HIGH_VOLTAGE_ENABLE_BIT]
        && !flash_operation_control[HIGH_VOLTAGE_ENABLE_BIT];
    // erase acts on the pump edge only if the function was selected beforehand
    assign page_erase = hv_rise && erase_armed
        && flash_operation_control[ERASE_SELECT_BIT]
        && !flash_operation_control[MASS_SELECT_BIT];
    // any protected range vetoes a mass erase
    assign mass_erase = hv_rise && flash_operation_control[ERASE_SELECT_BIT]
        && flash_operation_control[MASS_SELECT_BIT]
        && (flash_block_protection == PROT_NONE);
    assign ar_hs = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
    assign rd_array = (rd_rgn == RGN_USER) || (rd_rgn == RGN_VEC);
    // non-secure array reads are locked out once the lock is set
    assign rd_secured = security[SEC_LOCK_BIT] && S_AXI_ARPROT_IN[1] && rd_array;
    assign nb_idx = wr_mi ^ 12'h001;
    assign prog_old = mem[wr_mi];
    assign nb_old = mem[nb_idx];

    // ****************************************
    // write channels
    // ****************************************
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            aw_addr <= 32'h00000000;
            aw_full <= 1'b0;
            S_AXI_AWREADY_OUT <= 1'b1;
        end
        else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
        begin
            aw_addr <= S_AXI_AWADDR_IN;
            aw_full <= 1'b1;
            S_AXI_AWREADY_OUT <= 1'b0;
        end
        else if (do_write)
        begin
            aw_full <= 1'b0;
            S_AXI_AWREADY_OUT <= 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            w_full <= 1'b0;
            S_AXI_WREADY_OUT <= 1'b1;
        end
        else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
        begin
            w_data <= S_AXI_WDATA_IN;
            w_strb <= S_AXI_WSTRB_IN;
            w_full <= 1'b1;
            S_AXI_WREADY_OUT <= 1'b0;
        end
        else if (do_write)
        begin
            w_full <= 1'b0;
            S_AXI_WREADY_OUT <= 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT <= RESP_OKAY;
        end
        else if (do_write)
        begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT <= (wr_rgn == RGN_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (S_AXI_BREADY_IN)
        begin
            S_AXI_BVALID_OUT <= 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            flash_operation_control <= CTRL_RESET;
            flash_block_protection <= PROT_RESET;
            security <= SEC_RESET;
            HV_ACTIVE_OUT <= 1'b0;
        end
        else if (wr_byte)
        begin
            if (wr_rgn == RGN_CTRL)
            begin
                flash_operation_control <= {4'h0, w_data[3:0]};
                HV_ACTIVE_OUT <= w_data[HIGH_VOLTAGE_ENABLE_BIT];
            end
            if (wr_rgn == RGN_PROT)
                flash_block_protection <= w_data[7:0];
            // the lock only ever sets; reset is the sole way out
            if (wr_rgn == RGN_SEC && w_data[SEC_LOCK_BIT])
                security[SEC_LOCK_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            erase_page <= 6'h00;
            erase_armed <= 1'b0;
        end
        else if (page_erase || mass_erase || (wr_byte && wr_rgn == RGN_CTRL
                 && !w_data[ERASE_SELECT_BIT]))
        begin
            erase_armed <= 1'b0;
        end
        else if (latch_hit)
        begin
            erase_page <= wr_mi[11:6];
            erase_armed <= 1'b1;
        end
    end

    // ****************************************
    // array
    // ****************************************
    // no reset on the array: it stands for nonvolatile cells
    always_ff @(posedge CLK_IN)
    begin
        if (mass_erase)
        begin
            for (int i = 0; i < ARRAY_BYTES; i++)
                mem[i] <= ERASED_BYTE;
        end
        else if (page_erase)
        begin
            for (int i = 0; i < PAGE_BYTES; i++)
                if ({erase_page, 6'(i)} < ARRAY_BYTES)
                    mem[{erase_page, 6'(i)}] <= ERASED_BYTE;
        end
        else if (prog_hit)
        begin
            mem[wr_mi] <= prog_old & w_data[7:0];
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            S_AXI_ARREADY_OUT <= 1'b1;
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= 32'h00000000;
            S_AXI_RRESP_OUT <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RRESP_OUT <= (rd_rgn == RGN_NONE || rd_secured) ? RESP_SLVERR : RESP_OKAY;
            case (rd_rgn)
                RGN_CTRL: S_AXI_RDATA_OUT <= {24'h000000, flash_operation_control};
                RGN_PROT: S_AXI_RDATA_OUT <= {24'h000000, flash_block_protection};
                RGN_SEC: S_AXI_RDATA_OUT <= {24'h000000, security};
                RGN_USER, RGN_VEC: S_AXI_RDATA_OUT <= rd_secured ? 32'h00000000
                                                      : {24'h000000, mem[rd_mi]};
                default: S_AXI_RDATA_OUT <= 32'h00000000;
            endcase
        end
        else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
        begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_ARREADY_OUT <= 1'b1;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    prog_clears_only_a: assert property (
        @(posedge CLK_IN) disable iff (!NRST_IN)
        prog_hit |=> mem[$past(wr_mi)] == ($past(prog_old) & $past(w_data[7:0])))
        else $error("program write did not and the byte into the cell");

    page_fully_erased_a: assert property (
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (page_erase && erase_page < 6'h20) |=>
            mem[{$past(erase_page), 6'h00}] == ERASED_BYTE
            && mem[{$past(erase_page), 6'h3f}] == ERASED_BYTE)
        else $error("page erase left a byte of the page unerased");

    byte_grain_a: assert property (
        @(posedge CLK_IN) disable iff (!NRST_IN)
        prog_hit |=> mem[$past(nb_idx)] == $past(nb_old))
        else $error("byte program disturbed its neighbour");

    array_bound_a: assert property (
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (ar_hs && rd_array) |-> rd_mi < ARRAY_BYTES)
        else $error("array read index beyond the 2084 bytes");

    map_hole_a: assert property (
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (ar_hs && S_AXI_ARADDR_IN == 32'h0003d7fc) |=>
            S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == RESP_SLVERR)
        else $error("word just below user flash did not answer an error");

    secure_read_a: assert property (
        @(posedge CLK_IN) disable iff (!NRST_IN)
        (ar_hs && rd_secured) |=>
            S_AXI_RDATA_OUT == 32'h00000000 && S_AXI_RRESP_OUT == RESP_SLVERR)
        else $error("locked array contents leaked to a non-secure read");

endmodule : fpebpt_top

// File: tb/fpebpt_pump_model.sv
// charge pump watcher: times high voltage on and off periods for the bench
`timescale 1ns/1ps
module fpebpt_pump_model
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // pump state
    input wire logic hv_in,
    // measured periods
    output logic [31:0] hv_cycles_out,
    output logic [31:0] off_cycles_out
);
    // ****************************************
    // on time, kept across drops until reset clears it
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            hv_cycles_out <= 32'h0;
        else if (hv_in)
            hv_cycles_out <= hv_cycles_out + 32'h1;
    end

    // ****************************************
    // time since the pump was switched off; flash_op waits on it
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            off_cycles_out <= 32'h0;
        else if (hv_in)
            off_cycles_out <= 32'h0;
        else
            off_cycles_out <= off_cycles_out + 32'h1;
    end
endmodule : fpebpt_pump_model

// File: tb/test_flash_page_erase_byte_program_timing.sv
// register-level testbench for the flash sequencer
`timescale 1ns/1ps
module test_flash_page_erase_byte_program_timing;
    import fpebpt_pkg::*;
    // intervals in 4 ns cycles; erase intervals are shortened since the model erases at once
    localparam int SETUP = 2500;
    localparam int HOLD = 1250;
    localparam int MHOLD = 25000;
    localparam int RCV = 250;
    // 4 ms of pump time per row between erases
    localparam int HV_MAX = 1000000;
    // one 8 MHz bus cycle between array reads
    localparam int RD_GAP = 32;
    logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, hv;
    logic [31:0] awaddr, wdata, araddr, rdata, hv_cyc, off_cyc;
    logic [3:0] wstrb;
    logic [2:0] arprot;
    logic [1:0] bresp, rresp;
    int n_mismatch, check_count;

    fpebpt_top uut (.CLK_IN(clk), .NRST_IN(nrst), .S_AXI_AWADDR_IN(awaddr),
        .S_AXI_AWPROT_IN(3'h0), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARPROT_IN(arprot),
        .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
        .HV_ACTIVE_OUT(hv));
    fpebpt_pump_model pump (.clk_in(clk), .nrst_in(nrst), .hv_in(hv),
        .hv_cycles_out(hv_cyc), .off_cycles_out(off_cyc));

    function automatic logic [31:0] adr(input logic [15:0] i);
        return {14'h0000, i, 2'h0};
    endfunction : adr

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er,
                      input logic [3:0] s = 4'h1);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [7:0] ed, input logic [1:0] er,
                      input logic [2:0] p = 3'h0);
        repeat (RD_GAP) @(posedge clk);
        @(posedge clk);
        araddr <= a;
        arprot <= p;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        check("rdata", rdata, {24'h0, ed});
        check("rresp", {30'h0, rresp}, {30'h0, er});
    endtask : rd

    // select, setup, pump on, work, deselect, hold, pump off, recover
    task automatic flash_op(input logic [7:0] fn, input logic [31:0] a, input logic [7:0] d,
                            input int hold);
        wr(adr(CTRL_IDX), fn, RESP_OKAY);
        repeat (SETUP) @(posedge clk);
        wr(adr(CTRL_IDX), fn | 8'h08, RESP_OKAY);
        repeat (HOLD) @(posedge clk);
        check("hv_on", {31'h0, hv}, 32'h1);
        if (fn == 8'h01)
            wr(a, d, RESP_OKAY);
        wr(adr(CTRL_IDX), 8'h08, RESP_OKAY);
        repeat (hold) @(posedge clk);
        wr(adr(CTRL_IDX), 8'h00, RESP_OKAY);
        while (off_cyc < RCV) @(posedge clk);
        check("hv_off", {31'h0, hv}, 32'h0);
    endtask : flash_op

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        #(4 * 80000);
        n_mismatch++;
        summarize();
    end

    initial
    begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr, wstrb, arprot} = '0;
        n_mismatch = 0;
        check_count = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        // ****************************************
        // reset values and refused addresses
        // ****************************************
        rd(adr(CTRL_IDX), CTRL_RESET, RESP_OKAY);
        rd(adr(PROT_IDX), PROT_RESET, RESP_OKAY);
        wr(adr(16'h1000), 8'h55, RESP_SLVERR);
        rd(adr(16'h1000), 8'h00, RESP_SLVERR);
        rd(adr(16'hf5ff), 8'h00, RESP_SLVERR);
        wr(adr(CTRL_IDX), 8'hf0, RESP_OKAY);
        rd(adr(CTRL_IDX), 8'h00, RESP_OKAY);
        // ****************************************
        // mass erase leaves user and vector bytes reading ones
        // ****************************************
        flash_op(8'h06, 32'h0, 8'h00, MHOLD);
        rd(adr(USER_FIRST), ERASED_BYTE, RESP_OKAY);
        rd(adr(USER_LAST), ERASED_BYTE, RESP_OKAY);
        rd(adr(VEC_FIRST), ERASED_BYTE, RESP_OKAY);
        rd(adr(VEC_LAST), ERASED_BYTE, RESP_OKAY);
        // ****************************************
        // byte program across a page boundary
        // ****************************************
        flash_op(8'h01, adr(USER_FIRST), 8'ha5, HOLD);
        flash_op(8'h01, adr(USER_FIRST + 16'd63), 8'h3c, HOLD);
        flash_op(8'h01, adr(USER_FIRST + 16'd64), 8'h00, HOLD);
        wr(adr(USER_FIRST + 16'd1), 8'h00, RESP_OKAY, 4'h0);
        rd(adr(USER_FIRST), 8'ha5, RESP_OKAY);
        rd(adr(USER_FIRST + 16'd1), ERASED_BYTE, RESP_OKAY);
        rd(adr(USER_FIRST + 16'd63), 8'h3c, RESP_OKAY);
        rd(adr(USER_FIRST + 16'd64), 8'h00, RESP_OKAY);
        check("hv_total", {31'h0, (hv_cyc <= HV_MAX)}, 32'h1);
        // ****************************************
        // page erase clears page 0 only
        // ****************************************
        wr(adr(CTRL_IDX), 8'h02, RESP_OKAY);
        wr(adr(USER_FIRST + 16'd5), 8'h00, RESP_OKAY);
        flash_op(8'h02, 32'h0, 8'h00, HOLD);
        rd(adr(USER_FIRST), ERASED_BYTE, RESP_OKAY);
        rd(adr(USER_FIRST + 16'd63), ERASED_BYTE, RESP_OKAY);
        rd(adr(USER_FIRST + 16'd64), 8'h00, RESP_OKAY);
        // ****************************************
        // protected range refuses programming
        // ****************************************
        wr(adr(PROT_IDX), 8'hec, RESP_OKAY);
        rd(adr(PROT_IDX), 8'hec, RESP_OKAY);
        flash_op(8'h01, adr(USER_FIRST + 16'd2), 8'h00, HOLD);
        rd(adr(USER_FIRST + 16'd2), ERASED_BYTE, RESP_OKAY);
        wr(adr(PROT_IDX), PROT_NONE, RESP_OKAY);
        // ****************************************
        // lock hides the array from outside reads only
        // ****************************************
        wr(adr(SEC_IDX), 8'h01, RESP_OKAY);
        rd(adr(USER_FIRST + 16'd64), 8'h00, RESP_OKAY, 3'h0);
        rd(adr(USER_FIRST + 16'd63), 8'h00, RESP_SLVERR, 3'h2);
        summarize();
    end
endmodule : test_flash_page_erase_byte_program_timing
